// ===== rtl/hbp_port.sv
// Purpose: Eight-bit host bus port with input, bidir and reset pins
// Assumes: Register sets live outside; read data valid a cycle after req
// Notes:   Strobe convention is a static strap input, not a register
`timescale 1ns/100ps

// What this block does
// - General select opens all non-serial registers
// - Serial select opens serial-controller registers only
// - Separate strobes: write strobe low means write
// - Direction mode: line high read, low write
// - Separate strobes: read strobe low means read
// - Data strobe rising edge ends the access
// - Multiplexed: shared lines carry address then data
// - Drive data bus only while supplying reads
// - Latch transparent while enable high, holds after
// - First access after reset picks bus mode
// - Demultiplexed: address from dedicated address lines
// - Multiplexed: input port sampled at read or data strobe fall
// - Four-pin port, direction set per pin
// - Bidir input pins sampled at read or data strobe fall
// - Interrupt pin pulled low while pending, open drain
// - Reset indication high during any reset
// - External reset high holds the block reset
// - Eight-bit data path, demultiplexed addressing supported
module hbp_port
  import hbp_pkg::*;
(
  input  wire logic              clk,                  // 100 MHz
  input  wire logic              sys_rst,              // Sync reset
  input  wire logic              dir_line_mode,        // Strap: 1 dir+DS
  input  wire logic              general_reg_select_n, // Select, general
  input  wire logic              serial_ctrl_select_n, // Select, serial
  input  wire logic              wr_n_or_dir,          // Write or direction
  input  wire logic              rd_n_or_data_strobe,  // Read or data strobe
  input  wire logic              ale,                  // Address latch en
  input  wire logic [HBP_DW-1:0] shared_addr_data_in,  // Bus pin levels
  output logic      [HBP_DW-1:0] shared_addr_data_out, // Bus drive value
  output logic                   shared_addr_data_oe,  // Bus drive enable
  input  wire logic [HBP_AW-1:0] dedicated_addr_lines, // Address or port
  input  wire logic [HBP_BW-1:0] bidir_port_in,        // Bidir pin levels
  output logic      [HBP_BW-1:0] bidir_port_out,       // Bidir drive value
  output logic      [HBP_BW-1:0] bidir_port_oe,        // Bidir drive enable
  input  wire logic [HBP_BW-1:0] bidir_dir,            // 1 pin is output
  input  wire logic [HBP_BW-1:0] bidir_out_val,        // Output pin values
  output logic      [HBP_AW-1:0] input_port,           // Sampled port
  output logic      [HBP_BW-1:0] bidir_port_sampled,   // Sampled inputs
  input  wire logic              int_pending,          // Interrupt pending
  output logic                   int_n_out,            // Open drain value
  output logic                   int_n_oe,             // Pull low enable
  input  wire logic              ext_reset_in,         // Reset pin
  input  wire logic              por_reset,            // Power-up reset
  input  wire logic              wdt_reset,            // Watchdog reset
  input  wire logic              sw_reset,             // Software reset
  output logic                   reset_indication,     // Any reset active
  output logic                   mux_mode,             // 1 multiplexed
  output logic                   mode_known,           // Mode fixed
  output logic                   req_valid,            // One-cycle request
  output hbp_req_t               req,                  // Request fields
  input  wire logic [HBP_DW-1:0] rd_data               // Read data
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [HBP_CW-1:0] ctl;                  // Filtered control group
  logic [HBP_DW-1:0] ad_s;                 // Filtered shared bus
  logic [HBP_AW-1:0] addr_s;               // Filtered address lines
  logic [HBP_BW-1:0] bid_s;                // Filtered bidir pins

  hbp_sync #(.W(HBP_CW), .RST(HBP_CTL_IDLE)) u_sync_ctl (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     ({general_reg_select_n, serial_ctrl_select_n, wr_n_or_dir,
               rd_n_or_data_strobe, ale, ext_reset_in}),
    .level   (ctl)
  );

  // Data-side pins share one synchroniser; each bit still filters alone
  hbp_sync #(.W(HBP_DW + HBP_AW + HBP_BW),
             .RST({HBP_D_ZERO, HBP_A_ZERO, HBP_B_ZERO})) u_sync_dat (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     ({shared_addr_data_in, dedicated_addr_lines, bidir_port_in}),
    .level   ({ad_s, addr_s, bid_s})
  );

  // ==========================================================
  // Decode of the filtered pins
  // ==========================================================
  logic blk_rst;                           // Block reset incl. pin
  logic sel_gen;                           // General set selected
  logic sel_ser;                           // Serial set selected
  logic sel_any;                           // Any select low
  logic stb_on;                            // Strobe active
  logic stb_start;                         // Strobe fall, selected
  logic acc_write;                         // Access type is write

  // External reset pin holds the access and pin-driver registers in reset; synchronisers keep running
  assign blk_rst = sys_rst | ctl[HBP_C_XRST];
  assign sel_gen = ~ctl[HBP_C_GEN];
  assign sel_ser = ~ctl[HBP_C_SER];
  assign sel_any = sel_gen | sel_ser;

  // Strobe and type by bus convention
  always_comb begin
    if (dir_line_mode) begin
      stb_on    = ~ctl[HBP_C_STB];
      acc_write = ~ctl[HBP_C_WR];          // High read, low write
    end else begin
      stb_on    = ~ctl[HBP_C_STB] | ~ctl[HBP_C_WR];
      acc_write = ~ctl[HBP_C_WR];          // Write strobe low
    end
  end

  // ==========================================================
  // Access state machine and request
  // ==========================================================
  hbp_state_t state;                       // Access state
  hbp_state_t next_state;
  logic       stb_prev;                    // Strobe one cycle ago
  logic       next_req_valid;
  hbp_req_t   next_req;
  logic       acc_serial;                  // Target of open access
  logic       next_acc_serial;
  logic [HBP_AW-1:0] acc_addr;             // Address of open access
  logic [HBP_AW-1:0] next_acc_addr;
  logic [HBP_AW-1:0] addr_latch;           // Multiplexed address latch
  logic [HBP_AW-1:0] next_addr_latch;
  logic [HBP_DW-1:0] wdata;                // Last sampled write data
  logic [HBP_DW-1:0] next_wdata;
  logic       next_mux_mode;
  logic       next_mode_known;
  logic       ale_seen;                    // Enable pulsed since reset
  logic       next_ale_seen;
  logic       cur_mux;                     // Mode used by this access
  logic [HBP_AW-1:0] cur_addr;             // Address for this access

  // Access starts only on a fresh strobe fall with a select low
  assign stb_start = stb_on & ~stb_prev & sel_any;

  // First access after reset decides the mode; later ones reuse it
  assign cur_mux  = mode_known ? mux_mode
                               : (ale_seen & ~ctl[HBP_C_ALE]);
  assign cur_addr = cur_mux ? addr_latch : addr_s;

  always_comb begin
    next_state      = state;
    next_req_valid  = 1'b0;
    next_req        = req;
    next_acc_serial = acc_serial;
    next_acc_addr   = acc_addr;
    next_wdata      = wdata;
    next_mux_mode   = mux_mode;
    next_mode_known = mode_known;
    next_ale_seen   = ale_seen | ctl[HBP_C_ALE];
    // Latch follows the bus while enable is high, holds otherwise
    next_addr_latch = ctl[HBP_C_ALE] ? ad_s : addr_latch;
    case (state)
      HBP_IDLE: begin
        if (stb_start) begin
          // Mode is fixed by the first access only
          if (!mode_known) begin
            next_mux_mode   = cur_mux;
            next_mode_known = 1'b1;
          end
          next_acc_serial = sel_ser & ~sel_gen;
          next_acc_addr   = cur_addr;
          if (acc_write) begin
            next_state = HBP_WRITE;
          end else begin
            // Reads are requested at once so data can be driven
            next_state     = HBP_READ;
            next_req_valid = 1'b1;
            next_req       = '{write: 1'b0, serial: sel_ser & ~sel_gen,
                               addr: cur_addr, wdata: HBP_D_ZERO};
          end
        end
      end
      HBP_READ: begin
        // Strobe rise ends the read
        if (!stb_on) begin
          next_state = HBP_IDLE;
        end
      end
      HBP_WRITE: begin
        if (stb_on) begin
          // Keep the newest data while the strobe is active
          next_wdata = ad_s;
        end else begin
          // Write commits at the end so data had time to settle
          next_state     = HBP_IDLE;
          next_req_valid = 1'b1;
          next_req       = '{write: 1'b1, serial: acc_serial,
                             addr: acc_addr, wdata: wdata};
        end
      end
      default: begin
        next_state = HBP_IDLE;
      end
    endcase
  end

  // Register access state
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      state      <= HBP_IDLE;
      stb_prev   <= 1'b0;
      req_valid  <= 1'b0;
      req        <= HBP_REQ_ZERO;
      acc_serial <= 1'b0;
      acc_addr   <= HBP_A_ZERO;
      addr_latch <= HBP_A_ZERO;
      wdata      <= HBP_D_ZERO;
      mux_mode   <= 1'b0;
      mode_known <= 1'b0;
      ale_seen   <= 1'b0;
    end else begin
      state      <= next_state;
      stb_prev   <= stb_on;
      req_valid  <= next_req_valid;
      req        <= next_req;
      acc_serial <= next_acc_serial;
      acc_addr   <= next_acc_addr;
      addr_latch <= next_addr_latch;
      wdata      <= next_wdata;
      mux_mode   <= next_mux_mode;
      mode_known <= next_mode_known;
      ale_seen   <= next_ale_seen;
    end
  end

  // ==========================================================
  // Pin drivers and port sampling
  // ==========================================================
  logic [HBP_DW-1:0] next_ad_out;
  logic              next_ad_oe;
  logic [HBP_AW-1:0] next_input_port;
  logic [HBP_BW-1:0] next_bid_sampled;
  logic              any_reset;            // Any reset source active

  assign any_reset = blk_rst | por_reset | wdt_reset | sw_reset;

  always_comb begin
    // Drive only in an open read; enable registers with the state, no lag on release
    next_ad_oe  = (next_state == HBP_READ);
    next_ad_out = next_ad_oe ? rd_data : HBP_D_ZERO;
    next_input_port  = input_port;
    next_bid_sampled = bidir_port_sampled;
    if (stb_start && !ctl[HBP_C_STB]) begin
      // Read or data strobe fall only; address pins are a port when muxed
      if (cur_mux) begin
        next_input_port = addr_s;
      end
      for (int i = 0; i < HBP_BW; i++) begin
        if (!bidir_dir[i]) begin
          next_bid_sampled[i] = bid_s[i];
        end
      end
    end
  end

  // Register pin drivers
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      shared_addr_data_out <= HBP_D_ZERO;
      shared_addr_data_oe  <= 1'b0;
      input_port           <= HBP_A_ZERO;
      bidir_port_sampled   <= HBP_B_ZERO;
      bidir_port_out       <= HBP_B_ZERO;
      bidir_port_oe        <= HBP_B_ZERO;
      int_n_out            <= 1'b0;
      int_n_oe             <= 1'b0;
    end else begin
      shared_addr_data_out <= next_ad_out;
      shared_addr_data_oe  <= next_ad_oe;
      input_port           <= next_input_port;
      bidir_port_sampled   <= next_bid_sampled;
      bidir_port_out       <= bidir_out_val & bidir_dir;
      bidir_port_oe        <= bidir_dir;
      int_n_out            <= 1'b0;
      int_n_oe             <= int_pending;
    end
  end

  // Reset indication must show the pin reset too, so no blk_rst
  always_ff @(posedge clk) begin
    reset_indication <= any_reset;
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (blk_rst);
  sequence s_write_end;
    state == HBP_WRITE && !stb_on;
  endsequence
  sequence s_write_req;
    req_valid && req.write && state == HBP_IDLE;
  endsequence

  a_drive_in_read: assert property (
    shared_addr_data_oe |-> state == HBP_READ
      ##1 (!shared_addr_data_oe || shared_addr_data_out == $past(rd_data)))
    else $error("bus driven outside a read");
  a_noselect_quiet: assert property (
    (state == HBP_IDLE && !sel_any) |=> !req_valid && !shared_addr_data_oe)
    else $error("activity without select");
  a_read_target: assert property (
    (stb_start && state == HBP_IDLE && !acc_write) |=> req_valid
      && !req.write && req.serial == $past(sel_ser & ~sel_gen))
    else $error("read request target wrong");
  a_write_commit: assert property (
    s_write_end |=> s_write_req ##0 req.wdata == $past(wdata, 1))
    else $error("write not committed at strobe end");
  a_dir_read: assert property (
    (dir_line_mode && stb_start && state == HBP_IDLE && ctl[HBP_C_WR])
      |=> state == HBP_READ ##1 shared_addr_data_oe)
    else $error("direction high did not read");
  a_mode_locked: assert property (
    mode_known |=> mode_known && $stable(mux_mode))
    else $error("bus mode changed after first access");
  a_latch_follow: assert property (
    ctl[HBP_C_ALE] |=> addr_latch == $past(ad_s))
    else $error("address latch not transparent");
  a_port_sample: assert property (
    (stb_start && !ctl[HBP_C_STB] && cur_mux) |=> input_port == $past(addr_s))
    else $error("input port not sampled");
  a_int_pull: assert property (
    int_pending |=> int_n_oe && !int_n_out)
    else $error("interrupt not pulled low");
  a_reset_show: assert property (disable iff (1'b0)
    (por_reset || wdt_reset || sw_reset) |=> reset_indication)
    else $error("reset indication missing");

endmodule

// ===== rtl/hbp_pkg.sv
// Purpose: Shared types and constants of the host bus port block
// Assumes: Pins arrive asynchronous to clk and pass the synchroniser
// Notes:   Control pin group is packed in a fixed bit order below
package hbp_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int HBP_DW   = 8;             // Host data path width
  localparam int HBP_AW   = 8;             // Host address width
  localparam int HBP_BW   = 4;             // Bidirectional port width
  localparam int HBP_CW   = 6;             // Control pin group width

  // ==========================================================
  // Control pin group bit positions
  // ==========================================================
  localparam int HBP_C_GEN  = 5;           // General select, low active
  localparam int HBP_C_SER  = 4;           // Serial select, low active
  localparam int HBP_C_WR   = 3;           // Write strobe or direction
  localparam int HBP_C_STB  = 2;           // Read strobe or data strobe
  localparam int HBP_C_ALE  = 1;           // Address latch enable
  localparam int HBP_C_XRST = 0;           // External reset, high active

  // Idle level of the control group: selects and strobes high
  localparam logic [HBP_CW-1:0] HBP_CTL_IDLE = 6'h3c;
  localparam logic [HBP_DW-1:0] HBP_D_ZERO   = 8'h00;
  localparam logic [HBP_AW-1:0] HBP_A_ZERO   = 8'h00;
  localparam logic [HBP_BW-1:0] HBP_B_ZERO   = 4'h0;

  // ==========================================================
  // Access state machine
  // ==========================================================
  typedef enum logic [1:0] {
    HBP_IDLE  = 2'b00,                     // No access open
    HBP_READ  = 2'b01,                     // Read open, bus driven
    HBP_WRITE = 2'b10                      // Write open, data sampled
  } hbp_state_t;

  // Request toward the internal register sets
  typedef struct packed {
    logic              write;              // 1 write, 0 read
    logic              serial;             // 1 serial set, 0 general
    logic [HBP_AW-1:0] addr;               // Register address
    logic [HBP_DW-1:0] wdata;              // Write data
  } hbp_req_t;

  localparam hbp_req_t HBP_REQ_ZERO = '0;

endpackage

// ===== rtl/hbp_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/100ps
module hbp_sync #(
  parameter int               W   = 1,     // Group width
  parameter logic [W-1:0]     RST = '0     // Level held during reset
) (
  input  wire logic         clk,           // System clock
  input  wire logic         sys_rst,       // Synchronous reset
  input  wire logic [W-1:0] pin,           // Raw pin levels
  output logic      [W-1:0] level          // Filtered level
);

  // ==========================================================
  // Stages
  // ==========================================================
  logic [W-1:0] st1;                       // Metastable stage, st2 only
  logic [W-1:0] st2;                       // Second stage
  logic [W-1:0] st3;                       // Third stage
  logic [W-1:0] next_level;                // Next filtered level

  // Accept each bit once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_level[i] = (st2[i] == st3[i]) ? st3[i] : level[i];
    end
  end

  // Register stages
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st1   <= RST;
      st2   <= RST;
      st3   <= RST;
      level <= RST;
    end else begin
      st1   <= pin;
      st2   <= st1;
      st3   <= st2;
      level <= next_level;
    end
  end

endmodule

// ===== test/hbp_host_model.sv
// Purpose: Behavioural 8-bit host that runs pin-level bus cycles
// Assumes: Pins move on the falling clock edge, each phase 8 cycles
// Notes:   A released bus shows the inverse of its last value
`timescale 1ns/100ps
module hbp_host_model
  import hbp_pkg::*;
(
  input  wire logic              clk,      // Bench clock
  input  wire logic              dir_mode, // 1 direction line mode
  input  wire logic [HBP_DW-1:0] bus_pin,  // Resolved bus level
  output logic      [HBP_CW-1:0] ctl,      // Control pin group
  output logic      [HBP_DW-1:0] host_d,   // Host bus value
  output logic                   host_oe,  // Host drives bus
  output logic      [HBP_AW-1:0] addr_pin  // Dedicated lines
);
  // ==========================================================
  // Pin phases
  // ==========================================================
  initial begin
    ctl      = HBP_CTL_IDLE;
    host_d   = HBP_D_ZERO;
    host_oe  = 1'b0;
    addr_pin = HBP_A_ZERO;
  end
  // Phase of 8 cycles clears the 3-4 cycle pin filter
  task automatic phase();
    repeat (8) @(negedge clk);
  endtask
  // No keeper on the bus: never leave the old value standing
  task automatic release_bus();
    host_oe = 1'b0;
    host_d  = ~host_d;
  endtask
  task automatic pin_reset(input logic v);
    ctl[HBP_C_XRST] = v;
  endtask
  // One access; sel 0 general, 1 serial, 2 none
  task automatic access(input logic mux, input logic [1:0] sel,
    input logic wr, input logic [7:0] a, input logic [7:0] d,
    input logic [7:0] port, output logic [7:0] rd);
    if (mux) begin
      ctl[HBP_C_ALE] = 1'b1;
      host_oe = 1'b1;
      host_d = a;
      phase();
      ctl[HBP_C_ALE] = 1'b0;
      phase();
      addr_pin = port;
    end else begin
      addr_pin = a;
    end
    if (sel == 2'd0) ctl[HBP_C_GEN] = 1'b0;
    if (sel == 2'd1) ctl[HBP_C_SER] = 1'b0;
    if (wr) begin
      host_oe = 1'b1;
      host_d = d;
    end else begin
      release_bus();
    end
    // Direction settles before the data strobe falls
    if (dir_mode) ctl[HBP_C_WR] = ~wr;
    phase();
    ctl[HBP_C_WR] = ~wr;
    ctl[HBP_C_STB] = ~dir_mode & wr;
    phase();
    phase();
    rd = bus_pin;
    ctl[HBP_C_STB] = 1'b1;
    ctl[HBP_C_WR] = 1'b1;
    phase();
    ctl[HBP_C_GEN] = 1'b1;
    ctl[HBP_C_SER] = 1'b1;
    release_bus();
    phase();
  endtask
endmodule

// ===== test/tb_hbp_port.sv
// Purpose: Self-checking bench of the host bus port
// Assumes: Host model drives pins; register data is the inverted addr
// Notes:   Mode is locked per reset, so each mode gets its own reset
`timescale 1ns/100ps
module tb_hbp_port
  import hbp_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, dir_line_mode = 1'b0;
  logic [HBP_CW-1:0] ctl;
  logic [HBP_DW-1:0] shared_addr_data_in, shared_addr_data_out, host_d;
  logic [HBP_DW-1:0] rd_data, rv;
  logic [HBP_AW-1:0] dedicated_addr_lines, input_port;
  logic [HBP_BW-1:0] bidir_port_in = 4'ha, bidir_port_out, bidir_port_oe;
  logic [HBP_BW-1:0] bidir_dir = 4'h5, bidir_out_val = 4'hf;
  logic [HBP_BW-1:0] bidir_port_sampled;
  logic [2:0] src = 3'h0; // Internal reset sources
  logic host_oe, shared_addr_data_oe, int_pending = 1'b0, int_n_out;
  logic int_n_oe, reset_indication, mux_mode, mode_known, req_valid;
  hbp_req_t req;
  int err_total = 0, checked = 0, n_req = 0;
  // ==========================================================
  // Clock, wiring and monitors
  // ==========================================================
  always #5 clk = ~clk;
  assign shared_addr_data_in = shared_addr_data_oe ? shared_addr_data_out
                                                   : host_d;
  assign rd_data = ~req.addr; // Register set stand-in
  hbp_host_model host_u (.clk, .dir_mode(dir_line_mode),
    .bus_pin(shared_addr_data_in), .ctl, .host_d, .host_oe,
    .addr_pin(dedicated_addr_lines));
  hbp_port dut_u (.clk, .sys_rst, .dir_line_mode,
    .general_reg_select_n(ctl[HBP_C_GEN]),
    .serial_ctrl_select_n(ctl[HBP_C_SER]),
    .wr_n_or_dir(ctl[HBP_C_WR]), .rd_n_or_data_strobe(ctl[HBP_C_STB]),
    .ale(ctl[HBP_C_ALE]), .shared_addr_data_in, .shared_addr_data_out,
    .shared_addr_data_oe, .dedicated_addr_lines, .bidir_port_in,
    .bidir_port_out, .bidir_port_oe, .bidir_dir, .bidir_out_val,
    .input_port, .bidir_port_sampled, .int_pending, .int_n_out,
    .int_n_oe, .ext_reset_in(ctl[HBP_C_XRST]), .por_reset(src[0]),
    .wdt_reset(src[1]), .sw_reset(src[2]), .reset_indication,
    .mux_mode, .mode_known, .req_valid, .req, .rd_data);
  // Count request pulses; bus must stay undriven after a write
  always @(negedge clk) begin
    if (req_valid === 1'b1) n_req++;
    if (shared_addr_data_oe === 1'b1) check("oe wr", req.write, 0);
  end
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  // Multiplexed, separate strobes: read, write, unselected strobe
  task automatic sc_mux();
    int n0;
    dir_line_mode = 1'b0;
    do_reset();
    host_u.access(1, 0, 0, 8'h3c, 8'h00, 8'h96, rv);
    check("mode known", mode_known, 1);
    check("mux", mux_mode, 1);
    check("rd addr", req.addr, 8'h3c);
    check("rd kind", {req.write, req.serial}, 0);
    check("rd data", rv, 8'hc3);
    check("port", input_port, 8'h96);
    host_u.access(1, 1, 1, 8'h81, 8'h5a, 8'h11, rv);
    check("wr kind", {req.write, req.serial}, 8'h03);
    check("wr addr", req.addr, 8'h81);
    check("wr data", req.wdata, 8'h5a);
    n0 = n_req;
    host_u.access(1, 2, 0, 8'h44, 8'h00, 8'h22, rv);
    check("no sel req", n_req - n0, 0);
    check("no sel port", input_port, 8'h96);
    check("oe idle", shared_addr_data_oe, 0);
  endtask
  // Demultiplexed, direction line: read, write, bidir and interrupt
  task automatic sc_demux();
    int n0;
    dir_line_mode = 1'b1;
    do_reset();
    int_pending = 1'b1;
    n0 = n_req;
    host_u.access(0, 1, 0, 8'ha5, 8'h00, 8'h00, rv);
    check("demux", {mode_known, mux_mode}, 8'h02);
    check("rd addr", req.addr, 8'ha5);
    check("rd kind", {req.write, req.serial}, 8'h01);
    check("rd data", rv, 8'h5a);
    check("one req", n_req - n0, 1);
    check("bidir oe", bidir_port_oe, 4'h5);
    check("bidir out", bidir_port_out, 4'h5);
    check("bidir in", bidir_port_sampled & ~bidir_dir, 4'ha);
    check("int oe", {int_n_oe, int_n_out}, 8'h02);
    int_pending = 1'b0;
    host_u.access(0, 0, 1, 8'hff, 8'h69, 8'h00, rv);
    check("wr kind", {req.write, req.serial}, 8'h02);
    check("wr addr", req.addr, 8'hff);
    check("wr data", req.wdata, 8'h69);
    check("int off", int_n_oe, 0);
  endtask
  // Every reset source raises the indication; pin reset holds state
  task automatic sc_resets();
    for (int i = 0; i < 4; i++) begin
      if (i == 3) host_u.pin_reset(1'b1);
      else src[i] = 1'b1;
      repeat (8) @(negedge clk);
      check("rst ind on", reset_indication, 1);
      if (i == 3) check("held", {mode_known, req_valid}, 0);
      host_u.pin_reset(1'b0);
      src = 3'h0;
      repeat (8) @(negedge clk);
      check("rst ind off", reset_indication, 0);
    end
  endtask
  // ==========================================================
  // Main sequence and hang guard
  // ==========================================================
  initial begin
    sc_mux();
    sc_demux();
    sc_resets();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
